// [rtl/ucf_fault_response.sv]
// Undercurrent fault response controller with its configuration registers.
`timescale 1ns/1ps
`default_nettype none

module ucf_fault_response
	import ucf_pkg::*;
#(
	parameter int unsigned CONT_UNIT_CYCLES    = UCF_CONT_UNIT_CYC,
	parameter int unsigned RESTART_UNIT_CYCLES = UCF_RESTART_UNIT_CYC
)
(
	// Clock, reset and enable
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	// Command access
	input  wire logic [7:0]  cmd_i,
	input  wire logic        wr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        rd_i,
	output logic             rd_valid_o,
	output logic [15:0]      rd_data_o,
	// Measurement and control
	input  wire logic [15:0] iout_i,
	input  wire logic        clear_fault_i,
	input  wire logic        output_off_i,
	// Results
	output logic             out_permit_o,
	output logic             uc_status_o,
	output logic             alert_line_n_o,
	output logic             alert_line_oe_o
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]  resp_q;
	logic [15:0] uc_limit_q;
	logic [15:0] ot_limit_q;
	logic        uc_fault_q;
	logic        uc_fault_prev_q;
	logic        fault_rise;
	ucf_state_e  state_q;
	ucf_state_e  state_d;
	logic        timer_start;
	logic        attempt_clr;
	logic        attempt_inc;
	logic [2:0]  attempt_q;
	logic [UCF_TICK_W-1:0] tick_q;
	logic [UCF_TICK_W-1:0] tick_last;
	logic [2:0]  unit_q;
	logic        timer_done;
	logic [1:0]  mode;
	logic [2:0]  retry;
	logic [2:0]  delay;

	assign mode  = resp_q[UCF_MODE_MSB:UCF_MODE_LSB];
	assign retry = resp_q[UCF_RETRY_MSB:UCF_RETRY_LSB];
	assign delay = resp_q[UCF_DELAY_MSB:UCF_DELAY_LSB];

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			resp_q     <= UCF_RESP_RST;
			uc_limit_q <= UCF_UC_LIMIT_RST;
			ot_limit_q <= UCF_OT_LIMIT_RST;
		end
		else if (ce_i && wr_i)
		begin
			if (cmd_i == UCF_CMD_UC_RESP)
				resp_q <= wdata_i[7:0];
			if (cmd_i == UCF_CMD_UC_LIMIT)
				uc_limit_q <= wdata_i;
			if (cmd_i == UCF_CMD_OT_LIMIT)
				ot_limit_q <= wdata_i;
		end
	end

	// Unknown command codes read as zero.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= 16'h0000;
		end
		else if (ce_i)
		begin
			rd_valid_o <= rd_i;
			if (rd_i)
			begin
				unique case (cmd_i)
					UCF_CMD_UC_RESP:  rd_data_o <= {8'h00, resp_q};
					UCF_CMD_UC_LIMIT: rd_data_o <= uc_limit_q;
					UCF_CMD_OT_LIMIT: rd_data_o <= ot_limit_q;
					default:          rd_data_o <= 16'h0000;
				endcase
			end
		end
	end

	// ****************************************
	// Fault detection
	// ****************************************
	// Only the mantissas are compared, so the measurement must carry the threshold's exponent.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			uc_fault_q      <= 1'b0;
			uc_fault_prev_q <= 1'b0;
		end
		else if (ce_i)
		begin
			uc_fault_q      <= $signed(iout_i[UCF_MANT_MSB:0])
				< $signed(uc_limit_q[UCF_MANT_MSB:0]);
			uc_fault_prev_q <= uc_fault_q;
		end
	end

	assign fault_rise = uc_fault_q && !uc_fault_prev_q;

	// A new fault wins over a clear arriving in the same cycle.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			uc_status_o <= 1'b0;
		else if (ce_i)
		begin
			if (fault_rise)
				uc_status_o <= 1'b1;
			else if (clear_fault_i)
				uc_status_o <= 1'b0;
		end
	end

	assign alert_line_n_o  = 1'b0;
	assign alert_line_oe_o = uc_status_o;

	// ****************************************
	// Delay timer
	// ****************************************
	assign tick_last  = (state_q == UCF_CONT)
		? UCF_TICK_W'(CONT_UNIT_CYCLES - 1)
		: UCF_TICK_W'(RESTART_UNIT_CYCLES - 1);
	// The last tick of the final unit already counts as done, so N units last exactly N units.
	assign timer_done = (unit_q == delay)
		|| ((tick_q == tick_last) && (({1'b0, unit_q} + 4'h1) == {1'b0, delay}));

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_q <= '0;
			unit_q <= 3'h0;
		end
		else if (ce_i)
		begin
			if (timer_start)
			begin
				tick_q <= '0;
				unit_q <= 3'h0;
			end
			else if (!timer_done)
			begin
				if (tick_q == tick_last)
				begin
					tick_q <= '0;
					unit_q <= unit_q + 3'h1;
				end
				else
					tick_q <= tick_q + UCF_TICK_W'(1);
			end
		end
	end

	// ****************************************
	// Response sequencer
	// ****************************************
	always_comb
	begin
		state_d     = state_q;
		timer_start = 1'b0;
		attempt_clr = 1'b0;
		attempt_inc = 1'b0;
		unique case (state_q)
			UCF_RUN:
				if (uc_fault_q)
				begin
					unique case (mode)
						UCF_MODE_IGNORE:   state_d = UCF_RUN;
						UCF_MODE_CONTINUE:
						begin
							state_d     = UCF_CONT;
							timer_start = 1'b1;
						end
						UCF_MODE_DIS_RETRY:
						begin
							state_d     = (retry == UCF_RETRY_NONE) ? UCF_LATCH : UCF_OFF;
							timer_start = 1'b1;
							attempt_clr = 1'b1;
						end
						UCF_MODE_DIS_UNTIL: state_d = UCF_HOLD;
					endcase
				end
			UCF_CONT:
				if (timer_done)
				begin
					if (!uc_fault_q)
						state_d = UCF_RUN;
					else
					begin
						state_d     = (retry == UCF_RETRY_NONE) ? UCF_LATCH : UCF_OFF;
						timer_start = 1'b1;
						attempt_clr = 1'b1;
					end
				end
			UCF_OFF:
				if (timer_done)
				begin
					if (retry == UCF_RETRY_ENDLESS || attempt_q < retry)
					begin
						state_d     = UCF_TRY;
						timer_start = 1'b1;
						attempt_inc = 1'b1;
					end
					else
						state_d = UCF_LATCH;
				end
			UCF_TRY:
				if (uc_fault_q)
					state_d = UCF_OFF;
				else if (timer_done)
					state_d = UCF_RUN;
			UCF_LATCH:
				if (clear_fault_i)
					state_d = UCF_RUN;
			UCF_HOLD:
				if (!uc_fault_q)
					state_d = UCF_RUN;
		endcase
		// Commanding the output off ends any retry sequence, even an endless one.
		if (output_off_i)
		begin
			state_d     = UCF_RUN;
			timer_start = 1'b0;
			attempt_inc = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q      <= UCF_RUN;
			out_permit_o <= 1'b1;
		end
		else if (ce_i)
		begin
			state_q      <= state_d;
			out_permit_o <= (state_d == UCF_RUN) || (state_d == UCF_CONT)
				|| (state_d == UCF_TRY);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			attempt_q <= 3'h0;
		else if (ce_i)
		begin
			if (attempt_clr)
				attempt_q <= 3'h0;
			else if (attempt_inc && retry != UCF_RETRY_ENDLESS)
				attempt_q <= attempt_q + 3'h1;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_fault_in_run;
		ce_i && !output_off_i && state_q == UCF_RUN && uc_fault_q;
	endsequence

	sequence s_shut_off;
		!out_permit_o ##0 (state_q == UCF_OFF || state_q == UCF_LATCH);
	endsequence

	property p_alert_on_fault;
		ce_i && fault_rise |=> uc_status_o && alert_line_oe_o && !alert_line_n_o;
	endproperty
	a_alert_on_fault: assert property (p_alert_on_fault)
		else $error("Fault did not raise alert and status.");

	property p_ignore_keeps_output;
		s_fault_in_run and (mode == UCF_MODE_IGNORE) |=> out_permit_o && state_q == UCF_RUN;
	endproperty
	a_ignore_keeps_output: assert property (p_ignore_keeps_output)
		else $error("Ignore mode disturbed the output.");

	property p_disable_now;
		s_fault_in_run and (mode == UCF_MODE_DIS_RETRY) |=> s_shut_off;
	endproperty
	a_disable_now: assert property (p_disable_now)
		else $error("Output not disabled at once.");

	property p_hold_resume;
		ce_i && !output_off_i && state_q == UCF_HOLD && !uc_fault_q |=> state_q == UCF_RUN ##0 out_permit_o;
	endproperty
	a_hold_resume: assert property (p_hold_resume)
		else $error("Output did not resume after fault left.");

	property p_no_retry_latch;
		s_fault_in_run and (mode == UCF_MODE_DIS_RETRY && retry == UCF_RETRY_NONE) |=> state_q == UCF_LATCH;
	endproperty
	a_no_retry_latch: assert property (p_no_retry_latch)
		else $error("Retry code zero did not latch off.");

	property p_latch_stays;
		state_q == UCF_LATCH && !(ce_i && (clear_fault_i || output_off_i)) |=> state_q == UCF_LATCH [*1] ##0 !out_permit_o;
	endproperty
	a_latch_stays: assert property (p_latch_stays)
		else $error("Latched-off state left without a clear.");

	property p_attempt_bound;
		retry != UCF_RETRY_ENDLESS && state_q == UCF_TRY |-> attempt_q <= retry && attempt_q != 3'h0;
	endproperty
	a_attempt_bound: assert property (p_attempt_bound)
		else $error("Attempt count outside the retry setting.");

	property p_zero_delay;
		ce_i && !output_off_i && state_q == UCF_CONT && delay == 3'h0 |=> state_q != UCF_CONT;
	endproperty
	a_zero_delay: assert property (p_zero_delay)
		else $error("Zero delay still waited.");

	property p_unit_step;
		ce_i && !timer_start && !timer_done && tick_q == tick_last |=> unit_q == $past(unit_q) + 3'h1;
	endproperty
	a_unit_step: assert property (p_unit_step)
		else $error("Delay unit count did not advance.");

	property p_ot_write;
		ce_i && wr_i && cmd_i == UCF_CMD_OT_LIMIT |=> ot_limit_q == $past(wdata_i);
	endproperty
	a_ot_write: assert property (p_ot_write)
		else $error("Temperature threshold write lost.");

	property p_off_stops;
		ce_i && output_off_i |=> state_q == UCF_RUN;
	endproperty
	a_off_stops: assert property (p_off_stops)
		else $error("Off command did not end retries.");

endmodule

`default_nettype wire

// [rtl/ucf_pkg.sv]
// Constants and types shared by the undercurrent fault response controller.
package ucf_pkg;

	// ****************************************
	// Command codes of the configuration registers
	// ****************************************
	localparam logic [7:0] UCF_CMD_UC_LIMIT = 8'h4B;
	localparam logic [7:0] UCF_CMD_UC_RESP  = 8'h4C;
	localparam logic [7:0] UCF_CMD_OT_LIMIT = 8'h4F;

	// ****************************************
	// Field layout of the response byte and of the current mantissa
	// ****************************************
	localparam int UCF_MODE_MSB  = 7;
	localparam int UCF_MODE_LSB  = 6;
	localparam int UCF_RETRY_MSB = 5;
	localparam int UCF_RETRY_LSB = 3;
	localparam int UCF_DELAY_MSB = 2;
	localparam int UCF_DELAY_LSB = 0;
	localparam int UCF_MANT_MSB  = 10;

	localparam logic [1:0] UCF_MODE_IGNORE     = 2'h0;
	localparam logic [1:0] UCF_MODE_CONTINUE   = 2'h1;
	localparam logic [1:0] UCF_MODE_DIS_RETRY  = 2'h2;
	localparam logic [1:0] UCF_MODE_DIS_UNTIL  = 2'h3;
	localparam logic [2:0] UCF_RETRY_NONE      = 3'h0;
	localparam logic [2:0] UCF_RETRY_ENDLESS   = 3'h7;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0]  UCF_RESP_RST     = 8'h00;
	localparam logic [15:0] UCF_UC_LIMIT_RST = 16'h0000;
	localparam logic [15:0] UCF_OT_LIMIT_RST = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int UCF_CLK_PERIOD_NS     = 8;
	localparam int UCF_CONT_UNIT_NS      = 10_000_000;
	localparam int UCF_RESTART_UNIT_NS   = 8_200_000;
	localparam int UCF_CONT_UNIT_CYC     = UCF_CONT_UNIT_NS / UCF_CLK_PERIOD_NS;
	localparam int UCF_RESTART_UNIT_CYC  = UCF_RESTART_UNIT_NS / UCF_CLK_PERIOD_NS;
	localparam int UCF_TICK_W            = 21;

	typedef enum logic [2:0] {
		UCF_RUN,
		UCF_CONT,
		UCF_OFF,
		UCF_TRY,
		UCF_LATCH,
		UCF_HOLD
	} ucf_state_e;

endpackage

// [test/ucf_host_model.sv]
// Host model that issues command writes and reads to the fault response block.
`timescale 1ns/1ps
`default_nettype none
module ucf_host_model
(
	// Clock
	input  wire logic        clock_i,
	// Command access
	output logic [7:0]       cmd_o,
	output logic             wr_o,
	output logic [15:0]      wdata_o,
	output logic             rd_o,
	input  wire logic        rd_valid_i,
	input  wire logic [15:0] rd_data_i
);
	// ****************************************
	// Access tasks
	// ****************************************
	// Released lines are inverted so a stale word can never pass for a fresh one.
	initial
	begin
		cmd_o = 8'hFF;
		wr_o = 1'b0;
		wdata_o = 16'hFFFF;
		rd_o = 1'b0;
	end

	task automatic write_reg(input logic [7:0] cmd, input logic [15:0] data);
		@(posedge clock_i);
		#1;
		cmd_o = cmd;
		wdata_o = data;
		wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		wr_o = 1'b0;
		cmd_o = ~cmd_o;
		wdata_o = ~wdata_o;
	endtask

	task automatic read_reg(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
		@(posedge clock_i);
		#1;
		cmd_o = cmd;
		rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		rd_o = 1'b0;
		cmd_o = ~cmd_o;
		ok = 1'b0;
		data = 16'h0000;
		for (int n = 0; n < 4; n++)
		begin
			if (!ok && rd_valid_i === 1'b1)
			begin
				data = rd_data_i;
				ok = 1'b1;
			end
			if (!ok)
			begin
				@(posedge clock_i);
				#1;
			end
		end
	endtask
endmodule
`default_nettype wire

// [test/undercurrent_fault_response_test.sv]
// Self-checking testbench of the undercurrent fault response controller.
`timescale 1ns/1ps
`default_nettype none
module undercurrent_fault_response_test;
	import ucf_pkg::*;
	logic        clock_i, rst_n_i, ce_i, wr_i, rd_i, rd_valid_o;
	logic        clear_fault_i, output_off_i, out_permit_o, uc_status_o;
	logic        alert_line_n_o, alert_line_oe_o, prev_q, ok;
	logic [7:0]  cmd_i;
	logic [15:0] wdata_i, rd_data_o, iout_i, d;
	int          miscompares, check_count, cyc, rises, gap, last_rise;

	// ****************************************
	// Clock, monitor and instances
	// ****************************************
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	// Sampling on the falling edge sees the value that each rising edge has settled.
	always @(negedge clock_i)
	begin
		cyc++;
		if (out_permit_o === 1'b1 && prev_q === 1'b0)
		begin
			rises++;
			gap = cyc - last_rise;
			last_rise = cyc;
		end
		prev_q = out_permit_o;
	end

	ucf_host_model u_host (.clock_i(clock_i), .cmd_o(cmd_i), .wr_o(wr_i), .wdata_o(wdata_i),
		.rd_o(rd_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o));

	// Short units keep the run brief; expected spacings scale with them.
	ucf_fault_response #(.CONT_UNIT_CYCLES(4), .RESTART_UNIT_CYCLES(3)) u_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cmd_i(cmd_i), .wr_i(wr_i),
		.wdata_i(wdata_i), .rd_i(rd_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.iout_i(iout_i), .clear_fault_i(clear_fault_i), .output_off_i(output_off_i),
		.out_permit_o(out_permit_o), .uc_status_o(uc_status_o),
		.alert_line_n_o(alert_line_n_o), .alert_line_oe_o(alert_line_oe_o));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
		u_host.read_reg(cmd, d, ok);
		if (ok !== 1'b1)
		begin
			miscompares++;
			end_sim();
		end
		else
			chk(d, exp);
	endtask

	task automatic wait_permit(input logic v, input int max);
		for (int n = 0; n < max; n++)
		begin
			if (out_permit_o === v)
				return;
			tick(1);
		end
		chk({15'h0000, out_permit_o}, {15'h0000, v});
		miscompares++;
		end_sim();
	endtask

	// A healthy current, a cleared fault and an off command put the sequencer back in its running state.
	task automatic start(input logic [7:0] resp);
		iout_i = 16'h0200;
		output_off_i = 1'b1;
		clear_fault_i = 1'b1;
		tick(1);
		output_off_i = 1'b0;
		clear_fault_i = 1'b0;
		u_host.write_reg(UCF_CMD_UC_RESP, {8'h00, resp});
		tick(2);
		rises = 0;
		last_rise = cyc;
		iout_i = 16'h0010;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rst_n_i, clear_fault_i, output_off_i, prev_q} = 4'h0;
		ce_i = 1'b1;
		iout_i = 16'h0200;
		{miscompares, check_count, cyc, rises, gap, last_rise} = '0;
		tick(16);
		rst_n_i = 1'b1;
		rd_chk(UCF_CMD_UC_RESP, 16'h0000);
		rd_chk(UCF_CMD_OT_LIMIT, 16'h0000);
		u_host.write_reg(UCF_CMD_OT_LIMIT, 16'hA5C3);
		ce_i = 1'b0;
		u_host.write_reg(UCF_CMD_OT_LIMIT, 16'h1234);
		ce_i = 1'b1;
		rd_chk(UCF_CMD_OT_LIMIT, 16'hA5C3);
		rd_chk(8'h00, 16'h0000);
		u_host.write_reg(UCF_CMD_UC_LIMIT, 16'h0100);
		rd_chk(UCF_CMD_UC_LIMIT, 16'h0100);
		u_host.write_reg(UCF_CMD_UC_RESP, 16'hFF5A);
		rd_chk(UCF_CMD_UC_RESP, 16'h005A);
		start(8'h00);
		tick(20);
		chk({13'h0000, uc_status_o, alert_line_oe_o, alert_line_n_o}, 16'h0006);
		chk({15'h0000, out_permit_o}, 16'h0001);
		iout_i = 16'h0200;
		clear_fault_i = 1'b1;
		tick(1);
		clear_fault_i = 1'b0;
		tick(2);
		chk({15'h0000, uc_status_o}, 16'h0000);
		start(8'h80);
		wait_permit(1'b0, 6);
		iout_i = 16'h0200;
		tick(30);
		chk({15'h0000, out_permit_o}, 16'h0000);
		clear_fault_i = 1'b1;
		tick(1);
		clear_fault_i = 1'b0;
		wait_permit(1'b1, 4);
		chk({15'h0000, uc_status_o}, 16'h0000);
		start(8'hC0);
		wait_permit(1'b0, 6);
		tick(10);
		chk({15'h0000, out_permit_o}, 16'h0000);
		iout_i = 16'h0200;
		wait_permit(1'b1, 4);
		start(8'h92);
		tick(60);
		chk(rises[15:0], 16'h0002);
		chk(gap[15:0], 16'h0006);
		chk({15'h0000, out_permit_o}, 16'h0000);
		start(8'hB9);
		tick(60);
		chk({15'h0000, rises > 12}, 16'h0001);
		iout_i = 16'h0200;
		output_off_i = 1'b1;
		tick(1);
		output_off_i = 1'b0;
		wait_permit(1'b1, 4);
		start(8'h4B);
		tick(8);
		chk({15'h0000, out_permit_o}, 16'h0001);
		tick(5);
		chk({15'h0000, out_permit_o}, 16'h0001);
		tick(1);
		chk({15'h0000, out_permit_o}, 16'h0000);
		wait_permit(1'b0, 20);
		start(8'h48);
		wait_permit(1'b0, 6);
		end_sim();
	end
endmodule
`default_nettype wire
